//--- core/srbc_dip_filter.sv
// Noise rejection filter for the selected brown-out comparator.
// Assumes the comparator input is already synchronised to CLK_SYS.
`timescale 1ns/100ps
`default_nettype none
module srbc_dip_filter (
	input wire logic clk,
	input wire logic rst,
	input wire logic enable,
	input wire logic below,
	output logic trip
);
	logic [7:0] cnt_ff;
	logic trip_ff;

	// Count consecutive low samples; any recovery restarts the count
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_ff <= 8'h00;
		end else if (!(enable && below)) begin
			cnt_ff <= 8'h00;
		end else if (cnt_ff != srbc_pkg::FILTER_CYC) begin
			cnt_ff <= cnt_ff + 8'h01;
		end
	end

	// Trip only once the dip outlasts the filter time
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			trip_ff <= 1'b0;
		end else begin
			trip_ff <= enable && below && (cnt_ff == srbc_pkg::FILTER_CYC);
		end
	end

	assign trip = trip_ff;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_short_dip: assert property (!below |=> !trip_ff)
		else $error("Trip without a standing dip");
	a_dip_length: assert property ($rose(trip_ff) |-> $past(below, 1) && $past(below, 2) && $past(enable, 1))
		else $error("Trip after too short a dip");
endmodule
`default_nettype wire

//--- core/srbc_pkg.sv
// Constants shared by the supply reset and brown-out control block.
// Assumes a single 10 MHz system clock and static configuration bits.
package srbc_pkg;

	// ****************************************
	// Clock and timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 100;
	// Least duration of a supply dip that may cause a brown-out reset
	localparam int FILTER_TIME_NS = 1000;
	localparam int FILTER_CYC_RAW = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] FILTER_CYC = (FILTER_CYC_RAW < 1) ? 8'h01 : 8'(FILTER_CYC_RAW);

	// ****************************************
	// Brown-out modes
	// ****************************************
	typedef enum logic [1:0] {
		MODE_OFF = 2'h0,
		MODE_SOFT = 2'h1,
		MODE_NO_SLEEP = 2'h2,
		MODE_ALWAYS = 2'h3
	} srbc_mode_e;

	// ****************************************
	// Register port
	// ****************************************
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam int CTRL_SOFT_EN_BIT = 0;
	localparam int STAT_READY_BIT = 0;
	localparam int STAT_RESET_BIT = 1;
	localparam int STAT_ACTIVE_BIT = 2;
	localparam int STAT_MODE_LSB = 3;
	localparam int STAT_LEVEL_BIT = 5;
	localparam int STAT_EXEC_BIT = 6;
	localparam logic SOFT_EN_RESET = 1'b1;

	// Synchronised analog inputs
	localparam int SYNC_POR_OK = 0;
	localparam int SYNC_BELOW0 = 1;
	localparam int SYNC_BELOW1 = 2;
	localparam int SYNC_SETTLED = 3;
	localparam int SYNC_W = 4;

endpackage

//--- core/srbc_top.sv
// Supply reset and brown-out control: reset request and execution gate.
// Assumes analog comparator outputs arrive asynchronously, configuration
// bits and the sleep level come from CLK_SYS logic.
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module srbc_top (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic POR_SUPPLY_OK,
	input wire logic BOR_BELOW_LVL0,
	input wire logic BOR_BELOW_LVL1,
	input wire logic BOR_SETTLED,
	input wire logic [1:0] BROWNOUT_MODE_SELECT,
	input wire logic BROWNOUT_LEVEL_SELECT,
	input wire logic CORE_SLEEP,
	input wire logic [3:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	output logic RESET_REQ,
	output logic EXEC_EN,
	output logic BOR_ENABLE,
	output logic BOR_LEVEL_OUT,
	output logic BROWNOUT_READY_FLAG
);
	// ****************************************
	// Declarations
	// ****************************************
	typedef enum logic [3:0] {
		ST_HOLD = 4'h1,
		ST_WAIT = 4'h2,
		ST_RUN = 4'h4,
		ST_SLEEP = 4'h8
	} srbc_state_e;

	srbc_state_e state_ff, nxt_state;
	logic [srbc_pkg::SYNC_W-1:0] meta_ff, sync_ff, async_in;
	logic soft_en_ff, ready_ff, reset_ff, exec_ff, bor_en_ff, level_ff;
	logic [7:0] rdata_ff;
	logic active, awake_active, below_sel, trip, nxt_reset;
	srbc_pkg::srbc_mode_e mode;

	assign mode = srbc_pkg::srbc_mode_e'(BROWNOUT_MODE_SELECT);

	// ****************************************
	// Input synchronisers
	// ****************************************
	assign async_in[srbc_pkg::SYNC_POR_OK] = POR_SUPPLY_OK;
	assign async_in[srbc_pkg::SYNC_BELOW0] = BOR_BELOW_LVL0;
	assign async_in[srbc_pkg::SYNC_BELOW1] = BOR_BELOW_LVL1;
	assign async_in[srbc_pkg::SYNC_SETTLED] = BOR_SETTLED;

	// Two flops per analog line; first stage feeds nothing else
	genvar gi;
	generate
		for (gi = 0; gi < srbc_pkg::SYNC_W; gi++) begin : g_sync
			always_ff @(posedge CLK_SYS or posedge RST) begin
				if (RST) begin
					meta_ff[gi] <= 1'b0;
					sync_ff[gi] <= 1'b0;
				end else begin
					meta_ff[gi] <= async_in[gi];
					sync_ff[gi] <= meta_ff[gi];
				end
			end
		end
	endgenerate

	// ****************************************
	// Mode decode and detection
	// ****************************************
	// Activity as it would be while awake, used for wake decisions
	always_comb begin
		case (mode)
			srbc_pkg::MODE_ALWAYS: awake_active = 1'b1;
			srbc_pkg::MODE_NO_SLEEP: awake_active = 1'b1;
			srbc_pkg::MODE_SOFT: awake_active = soft_en_ff;
			default: awake_active = 1'b0;
		endcase
	end

	// Mode 10 drops detection while the core sleeps
	assign active = awake_active && !(mode == srbc_pkg::MODE_NO_SLEEP && CORE_SLEEP);
	assign below_sel = BROWNOUT_LEVEL_SELECT ? sync_ff[srbc_pkg::SYNC_BELOW1]
		: sync_ff[srbc_pkg::SYNC_BELOW0];

	srbc_dip_filter u_filter (
		.clk(CLK_SYS),
		.rst(RST),
		.enable(active),
		.below(below_sel),
		.trip(trip)
	);

	// Reset request: power-on hold, or a filtered brown-out while active
	assign nxt_reset = !sync_ff[srbc_pkg::SYNC_POR_OK] || (active && trip);

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			reset_ff <= 1'b1;
		end else begin
			reset_ff <= nxt_reset;
		end
	end

	// Analog enable and level mirror the decoded configuration
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			bor_en_ff <= 1'b0;
			level_ff <= 1'b0;
		end else begin
			bor_en_ff <= active;
			level_ff <= BROWNOUT_LEVEL_SELECT;
		end
	end

	// Ready only after settling while enabled; cleared when disabled
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			ready_ff <= 1'b0;
		end else begin
			ready_ff <= active && (ready_ff || sync_ff[srbc_pkg::SYNC_SETTLED]);
		end
	end

	// ****************************************
	// Execution gate
	// ****************************************
	// Power-on release waits for ready whenever detection is active
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_HOLD: begin
				if (!reset_ff) begin
					nxt_state = active ? ST_WAIT : ST_RUN;
				end
			end
			ST_WAIT: begin
				if (reset_ff) begin
					nxt_state = ST_HOLD;
				end else if (ready_ff || !active) begin
					nxt_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (reset_ff) begin
					nxt_state = ST_HOLD;
				end else if (CORE_SLEEP) begin
					nxt_state = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (reset_ff) begin
					nxt_state = ST_HOLD;
				end else if (!CORE_SLEEP) begin
					// Always-on keeps its protection, so wake is not held up
					nxt_state = (awake_active && mode != srbc_pkg::MODE_ALWAYS) ? ST_WAIT : ST_RUN;
				end
			end
			default: nxt_state = ST_HOLD;
		endcase
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			state_ff <= ST_HOLD;
			exec_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			exec_ff <= (nxt_state == ST_RUN);
		end
	end

	// ****************************************
	// Register port
	// ****************************************
	// Software enable survives sleep; a block reset restores it, a write to ADDR_CTRL loads it from CTRL_SOFT_EN_BIT
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			soft_en_ff <= srbc_pkg::SOFT_EN_RESET;
		end else if (REG_WR && REG_ADDR == srbc_pkg::ADDR_CTRL) begin
			soft_en_ff <= REG_WDATA[srbc_pkg::CTRL_SOFT_EN_BIT];
		end
	end

	// Read data stands for one cycle only; unmapped reads give zero
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			rdata_ff <= 8'h00;
		end else begin
			rdata_ff <= 8'h00;
			if (REG_RD && REG_ADDR == srbc_pkg::ADDR_CTRL) begin
				rdata_ff[srbc_pkg::CTRL_SOFT_EN_BIT] <= soft_en_ff;
			end else if (REG_RD && REG_ADDR == srbc_pkg::ADDR_STATUS) begin
				rdata_ff[srbc_pkg::STAT_READY_BIT] <= ready_ff;
				rdata_ff[srbc_pkg::STAT_RESET_BIT] <= reset_ff;
				rdata_ff[srbc_pkg::STAT_ACTIVE_BIT] <= bor_en_ff;
				rdata_ff[srbc_pkg::STAT_MODE_LSB +: 2] <= BROWNOUT_MODE_SELECT;
				rdata_ff[srbc_pkg::STAT_LEVEL_BIT] <= level_ff;
				rdata_ff[srbc_pkg::STAT_EXEC_BIT] <= exec_ff;
			end
		end
	end

	assign REG_RDATA = rdata_ff;
	assign RESET_REQ = reset_ff;
	assign EXEC_EN = exec_ff;
	assign BOR_ENABLE = bor_en_ff;
	assign BOR_LEVEL_OUT = level_ff;
	assign BROWNOUT_READY_FLAG = ready_ff;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);

	// Execution gate lags the reset request by one cycle, as in the brown-out path
	a_por_hold: assert property (!sync_ff[srbc_pkg::SYNC_POR_OK] |=> RESET_REQ ##1 !EXEC_EN)
		else $error("No reset while supply below minimum");
	a_bor_reset: assert property (active && trip |=> RESET_REQ ##1 !EXEC_EN)
		else $error("Brown-out trip did not reset");
	a_mode_off: assert property (mode == srbc_pkg::MODE_OFF |=> !BOR_ENABLE && !BROWNOUT_READY_FLAG)
		else $error("Detection active in off mode");
	// Mirrors hold reset values on the first edges after release, so skip those
	a_level_follow: assert property (!$past(RST) |-> BOR_LEVEL_OUT == $past(BROWNOUT_LEVEL_SELECT))
		else $error("Threshold level not followed");
	a_always_on: assert property (!$past(RST) && mode == srbc_pkg::MODE_ALWAYS |=> BOR_ENABLE)
		else $error("Always-on mode not active");
	a_wait_ready: assert property (state_ff == ST_WAIT && !ready_ff && active && !reset_ff |=> !EXEC_EN)
		else $error("Execution started before ready");
	a_sleep_off: assert property (mode == srbc_pkg::MODE_NO_SLEEP && CORE_SLEEP |=> !BOR_ENABLE)
		else $error("Detection active in sleep");
	a_wake_fast: assert property (state_ff == ST_SLEEP && !CORE_SLEEP && !reset_ff
		&& mode == srbc_pkg::MODE_ALWAYS |=> EXEC_EN)
		else $error("Always-on wake was delayed");
	a_soft_on: assert property (!$past(RST) && mode == srbc_pkg::MODE_SOFT && soft_en_ff |=> BOR_ENABLE)
		else $error("Software enable ignored");
	a_off_run: assert property (state_ff == ST_HOLD && !reset_ff && !active |=> EXEC_EN)
		else $error("Disabled mode delayed execution");
	a_ready_gated: assert property (BROWNOUT_READY_FLAG |-> BOR_ENABLE)
		else $error("Ready while detection disabled");

	c_bor_trip: cover property (active && trip ##1 RESET_REQ);
	c_wait_run: cover property (state_ff == ST_WAIT ##1 state_ff == ST_RUN);
	c_sleep_wake: cover property (state_ff == ST_SLEEP ##1 state_ff == ST_WAIT);
endmodule
`default_nettype wire

//--- verification/srbc_supply_model.sv
// Behavioural model of the analog supply monitor: power-on detector,
// two brown-out comparators and a settle delay. Supply set by the bench in mV.
`timescale 1ns/100ps
`default_nettype none
module srbc_supply_model #(
	parameter int POR_MV = 1800,
	parameter int LVL0_MV = 2450,
	parameter int LVL1_MV = 2700,
	parameter int SETTLE_CYC = 5
) (
	input wire logic clk,
	input var int supply_mv,
	input wire logic bor_enable,
	output logic por_ok,
	output logic below0,
	output logic below1,
	output logic settled
);
	logic [7:0] settle_cnt_ff;
	// ****************************************
	// Comparators
	// ****************************************
	// Disabled comparators claim a low supply, so a block that listens anyway trips
	assign por_ok = supply_mv >= POR_MV;
	assign below0 = !bor_enable || supply_mv < LVL0_MV;
	assign below1 = !bor_enable || supply_mv < LVL1_MV;
	// Settling restarts on every enable; never ready at once
	always_ff @(posedge clk) begin
		if (!bor_enable) begin
			settle_cnt_ff <= 8'h00;
		end else if (settle_cnt_ff < 8'(SETTLE_CYC)) begin
			settle_cnt_ff <= settle_cnt_ff + 8'h01;
		end
	end
	assign settled = bor_enable && settle_cnt_ff >= 8'(SETTLE_CYC);
endmodule
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the supply reset and brown-out control block.
// Assumes the behavioural supply model stands on the analog side.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic CLK_SYS = 1'b0;
	logic RST = 1'b1;
	logic [1:0] BROWNOUT_MODE_SELECT = 2'h3;
	logic BROWNOUT_LEVEL_SELECT = 1'b0;
	logic CORE_SLEEP = 1'b0;
	logic [3:0] REG_ADDR = 4'h0;
	logic [7:0] REG_WDATA = 8'h00;
	logic REG_WR = 1'b0;
	logic REG_RD = 1'b0;
	logic [7:0] REG_RDATA;
	logic RESET_REQ, EXEC_EN, BOR_ENABLE, BOR_LEVEL_OUT, BROWNOUT_READY_FLAG;
	logic POR_SUPPLY_OK, BOR_BELOW_LVL0, BOR_BELOW_LVL1, BOR_SETTLED;
	int supply_mv = 3300;
	int bad_count = 0;
	int checked = 0;
	int cyc = 0;
	logic [7:0] d, e;
	logic act;
	// ****************************************
	// Clock, instances, timeout
	// ****************************************
	always #50 CLK_SYS = ~CLK_SYS;
	srbc_top i_dut (.CLK_SYS, .RST, .POR_SUPPLY_OK, .BOR_BELOW_LVL0, .BOR_BELOW_LVL1, .BOR_SETTLED,
		.BROWNOUT_MODE_SELECT, .BROWNOUT_LEVEL_SELECT, .CORE_SLEEP, .REG_ADDR, .REG_WDATA, .REG_WR,
		.REG_RD, .REG_RDATA, .RESET_REQ, .EXEC_EN, .BOR_ENABLE, .BOR_LEVEL_OUT, .BROWNOUT_READY_FLAG);
	srbc_supply_model i_sup (.clk(CLK_SYS), .supply_mv(supply_mv), .bor_enable(BOR_ENABLE),
		.por_ok(POR_SUPPLY_OK), .below0(BOR_BELOW_LVL0), .below1(BOR_BELOW_LVL1), .settled(BOR_SETTLED));
	// Whole run is a few hundred cycles
	always @(posedge CLK_SYS) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			final_report();
		end
	end
	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge CLK_SYS);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge CLK_SYS);
		REG_ADDR <= a;
		REG_WDATA <= v;
		REG_WR <= 1'b1;
		@(posedge CLK_SYS);
		REG_WR <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge CLK_SYS);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge CLK_SYS);
		REG_RD <= 1'b0;
		#1;
		v = REG_RDATA;
	endtask
	// Bounded wait for the execution gate
	task automatic wait_exec();
		int n;
		n = 0;
		while (EXEC_EN !== 1'b1 && n < 200) begin
			tick(1);
			n++;
		end
	endtask
	// Reset held 20 cycles; the model settles only after release, within wait_exec
	task automatic boot(input logic [1:0] m, input logic l);
		@(posedge CLK_SYS);
		RST <= 1'b1;
		BROWNOUT_MODE_SELECT <= m;
		BROWNOUT_LEVEL_SELECT <= l;
		CORE_SLEEP <= 1'b0;
		repeat (20) @(posedge CLK_SYS);
		RST <= 1'b0;
		wait_exec();
	endtask
	// Supply held at mv for n+1 sampled cycles
	task automatic dip(input int mv, input int n, input logic x);
		@(posedge CLK_SYS);
		supply_mv <= mv;
		tick(n);
		chk("dip_req", 8'(x), 8'(RESET_REQ));
		@(posedge CLK_SYS);
		supply_mv <= 3300;
		tick(6);
		if (!x) chk("dip_after", 8'h00, 8'(RESET_REQ));
		wait_exec();
	endtask
	task automatic final_report();
		if (bad_count == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		for (int m = 0; m < 4; m++) begin
			act = (m != 0);
			boot(2'(m), m[0]);
			chk("exec", 8'h01, 8'(EXEC_EN));
			chk("level_out", 8'(m[0]), 8'(BOR_LEVEL_OUT));
			rd(srbc_pkg::ADDR_STATUS, d);
			e = 8'h00;
			e[srbc_pkg::STAT_READY_BIT] = act;
			e[srbc_pkg::STAT_ACTIVE_BIT] = act;
			e[srbc_pkg::STAT_MODE_LSB+:2] = 2'(m);
			e[srbc_pkg::STAT_LEVEL_BIT] = m[0];
			e[srbc_pkg::STAT_EXEC_BIT] = 1'b1;
			chk("status", e, d);
			dip(2000, 9, 1'b0);
			dip(2600, 19, act && m[0]);
			@(posedge CLK_SYS);
			CORE_SLEEP <= 1'b1;
			tick(4);
			chk("sleep_exec", 8'h00, 8'(EXEC_EN));
			chk("sleep_active", 8'(m == 3 || m == 1), 8'(BOR_ENABLE));
			@(posedge CLK_SYS);
			CORE_SLEEP <= 1'b0;
			tick(2);
			if (m != 1) chk("wake_exec", 8'(m != 2), 8'(EXEC_EN));
			wait_exec();
			chk("wake_done", 8'h01, 8'(EXEC_EN));
			if (m == 1) begin
				wr(srbc_pkg::ADDR_CTRL, 8'h00);
				tick(3);
				chk("soft_off", 8'h00, 8'(BOR_ENABLE));
				chk("soft_ready", 8'h00, 8'(BROWNOUT_READY_FLAG));
				act = 1'b0;
			end
			dip(2000, 19, act);
		end
		rd(4'h8, d);
		chk("unmapped", 8'h00, d);
		@(posedge CLK_SYS);
		supply_mv <= 1000;
		tick(4);
		chk("por_req", 8'h01, 8'(RESET_REQ));
		chk("por_exec", 8'h00, 8'(EXEC_EN));
		@(posedge CLK_SYS);
		supply_mv <= 3300;
		wait_exec();
		chk("por_back", 8'h01, 8'(EXEC_EN));
		final_report();
	end
endmodule
`default_nettype wire
